// ---- verilog/mdp_monitor.sv ----
/*
 * motor drive protection monitor: overload warning and trip, stall
 * prevention, phase loss, external trips, drive overload and routing of
 * flags to the open-collector and relay outputs; AXI4-Lite registers.
 * assumes measured currents, dc link level and ramp state come in
 * synchronous to aclk from logic outside this block.
 */
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/10ps

// Summary of operation
// [RL1] overload warn level 30-150 %, time 0-30 s
// [RL2] function 5 routes warning to either output
// [RL3] trip enable set turns output off on overload
// [RL4] trip after current over level for trip time
// [RL5] accel stall halts ramp above stall level
// [RL6] constant speed stall forces deceleration
// [RL7] decel stall halts ramp on high dc link
// [RL8] stall select bits: accel, constant, decel
// [RL9] stall level percent of motor rated current
// [RL10] function 7 shows stall while stall acting
// [RL11] stall may stretch ramps beyond set times
// [RL12] phase loss low bit: output phase loss trips
// [RL13] high bit: input loss or capacitor trips
// [RL14] value 3 enables both phase checks
// [RL15] phase loss select is two independent bits
// [RL16] input codes 0-29, 18 open, 19 closed trip
// [RL17] normally-open trip input closed gives fault
// [RL18] normally-closed trip input open gives fault
// [RL19] drive overload over rated, alarm function 6
// [RL20] output selectors default 12 and 17
// [RL21] warning after continuous time, clears below
module mdp_monitor
    import mdp_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] motor_current,
    input wire logic [15:0] drive_current,
    input wire logic dc_link_high,
    input wire logic ramp_accel,
    input wire logic ramp_const,
    input wire logic ramp_decel,
    input wire logic run_active,
    input wire logic [2:0] out_phase_lost,
    input wire logic [2:0] in_phase_lost,
    input wire logic cap_replace,
    input wire logic [7:0] multi_input,
    output logic open_collector_output,
    output logic changeover_relay_output,
    output logic output_enable,
    output logic fault,
    output logic overload_warn_flag,
    output logic stall_hold_accel,
    output logic stall_force_decel,
    output logic stall_hold_decel,
    output logic stall_active
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic over_pct(
        input logic [15:0] cur,
        input logic [7:0] pct,
        input logic [15:0] rated
    );
        logic [31:0] lhs;
        logic [31:0] rhs;
        lhs = {16'h0000, cur} * PCT_SCALE;
        rhs = {24'h00_0000, pct} * {16'h0000, rated};
        over_pct = lhs > rhs;
    endfunction

    function automatic logic [31:0] wmerge(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = data[8*b +: 8];
            end
        end
        wmerge = res;
    endfunction

    function automatic logic route(
        input logic [4:0] sel,
        input logic [7:0] flags
    );
        logic r;
        r = 1'b0;
        unique case (sel)
            FN_OVL_WARN: r = flags[0];
            FN_DRV_OVL: r = flags[1];
            FN_STALL: r = flags[2];
            FN_RUN: r = flags[3];
            FN_FAULT: r = flags[4];
            default: r = 1'b0;
        endcase
        route = r;
    endfunction

    function automatic logic [5:0] count_up(
        input logic [5:0] cnt,
        input logic above,
        input logic tick
    );
        logic [5:0] res;
        res = cnt;
        if (!above) begin
            res = 6'h00;
        end else if (tick && cnt != 6'h3F) begin
            res = cnt + 6'h01;
        end
        count_up = res;
    endfunction

    mdp_state_t st_r;
    mdp_state_t st_nxt;

    // ------------------------------------------------------------
    // configuration fields
    // ------------------------------------------------------------
    logic [7:0] warn_lvl;
    logic [5:0] warn_time;
    logic [7:0] trip_lvl;
    logic [5:0] trip_time;
    logic [2:0] stall_sel;
    logic trip_en;
    logic [1:0] ploss_sel;
    logic [7:0] stall_lvl;
    logic [4:0] oc_fn;
    logic [4:0] relay_fn;
    logic [15:0] motor_rated_current;
    logic [15:0] drive_rated_current;
    logic [63:0] infn;

    assign warn_lvl = st_r.levels[WARN_LVL_POS +: 8];
    assign warn_time = st_r.levels[WARN_TIME_POS +: 6];
    assign trip_lvl = st_r.levels[TRIP_LVL_POS +: 8];
    assign trip_time = st_r.levels[TRIP_TIME_POS +: 6];
    assign stall_sel = st_r.ctrl[STALL_SEL_POS +: 3];
    assign trip_en = st_r.ctrl[TRIP_EN_POS];
    assign ploss_sel = st_r.ctrl[PLOSS_POS +: 2];
    assign stall_lvl = st_r.ctrl[STALL_LVL_POS +: 8];
    assign oc_fn = st_r.ctrl[OC_FN_POS +: 5];
    assign relay_fn = st_r.ctrl[RELAY_FN_POS +: 5];
    assign motor_rated_current = st_r.rated[MOTOR_RATED_POS +: 16];
    assign drive_rated_current = st_r.rated[DRIVE_RATED_POS +: 16];
    assign infn = {st_r.infn_hi, st_r.infn_lo};

    // ------------------------------------------------------------
    // external trip inputs
    // ------------------------------------------------------------
    logic [7:0] ext_hit;

    for (genvar i = 0; i < 8; i++) begin : g_ext
        logic [4:0] fn;
        assign fn = infn[8*i +: 5];
        // [RL16] [RL17] [RL18] contact type decode
        assign ext_hit[i] = (fn == IN_EXT_NO && multi_input[i]) ||
                            (fn == IN_EXT_NC && !multi_input[i]);
    end

    // ------------------------------------------------------------
    // protection conditions
    // ------------------------------------------------------------
    logic warn_above;
    logic trip_above;
    logic stall_above;
    logic drv_over;
    logic [4:0] trip_set;
    logic [2:0] stall_act;
    logic [7:0] flags;

    assign warn_above = over_pct(motor_current, warn_lvl,
                                 motor_rated_current);
    assign trip_above = over_pct(motor_current, trip_lvl,
                                 motor_rated_current);
    // [RL9] stall level scaling
    assign stall_above = over_pct(motor_current, stall_lvl,
                                  motor_rated_current);
    assign drv_over = drive_current > drive_rated_current;

    always_comb begin
        trip_set = 5'h00;
        // [RL3] [RL4] overload trip qualify
        trip_set[TR_OVL] = trip_en && trip_above &&
                           st_r.trip_cnt >= trip_time;
        // [RL12] [RL14] [RL15] output phase check
        trip_set[TR_OUTPH] = ploss_sel[0] && |out_phase_lost;
        // [RL13] [RL14] [RL15] input phase check
        trip_set[TR_INPH] = ploss_sel[1] &&
                            (|in_phase_lost || cap_replace);
        // [RL17] [RL18] external fault
        trip_set[TR_EXT] = |ext_hit;
        // [RL19] drive overload trip
        trip_set[TR_DRV] = drv_over;
    end

    // [RL5] [RL6] [RL7] [RL8] stall actions per ramp phase
    assign stall_act[0] = stall_sel[0] && ramp_accel && stall_above;
    assign stall_act[1] = stall_sel[1] && ramp_const && stall_above;
    assign stall_act[2] = stall_sel[2] && ramp_decel && dc_link_high;

    assign flags = {3'h0, |st_r.trips, run_active, |st_r.stall,
                    st_r.trips[TR_DRV], st_r.warn};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic do_write;
    logic ar_take;
    logic wr_map;
    logic [31:0] clr_mask;
    logic [31:0] status;

    assign do_write = st_r.aw_hold && st_r.w_hold && !st_r.bvalid;
    assign ar_take = s_axi_arvalid && !st_r.rvalid;
    assign wr_map = st_r.aw_addr inside {ADDR_LEVELS, ADDR_CTRL,
                                         ADDR_RATED, ADDR_INFN_LO,
                                         ADDR_INFN_HI, ADDR_STATUS};

    always_comb begin
        status = 32'h0000_0000;
        status[ST_WARN_POS] = st_r.warn;
        status[ST_TRIP_POS +: 5] = st_r.trips;
        status[ST_STALL_POS +: 3] = st_r.stall;
    end

    always_comb begin
        st_nxt = st_r;
        clr_mask = 32'h0000_0000;

        st_nxt.tick = 1'b0;
        if (st_r.presc >= 25'(TICK_CYCLES - 1)) begin
            st_nxt.presc = 25'h000_0000;
            st_nxt.tick = 1'b1;
        end else begin
            st_nxt.presc = st_r.presc + 25'h000_0001;
        end

        // [RL1] [RL21] warning qualifying time
        st_nxt.warn_cnt = count_up(st_r.warn_cnt, warn_above, st_r.tick);
        st_nxt.warn = warn_above && st_r.warn_cnt >= warn_time;
        // [RL4] trip qualifying time
        st_nxt.trip_cnt = count_up(st_r.trip_cnt, trip_above, st_r.tick);
        // [RL11] stall only holds or forces decel, never times ramps
        st_nxt.stall = stall_act;
        // [RL2] [RL10] [RL19] [RL20] output routing
        st_nxt.oc = route(oc_fn, flags);
        st_nxt.relay = route(relay_fn, flags);

        // write address and data, either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_hold = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_hold = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            st_nxt.aw_hold = 1'b0;
            st_nxt.w_hold = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = wr_map ? RESP_OKAY : RESP_SLVERR;
            unique case (st_r.aw_addr)
                ADDR_LEVELS: st_nxt.levels = wmerge(st_r.levels,
                    st_r.w_data, st_r.w_strb);
                ADDR_CTRL: st_nxt.ctrl = wmerge(st_r.ctrl,
                    st_r.w_data, st_r.w_strb);
                ADDR_RATED: st_nxt.rated = wmerge(st_r.rated,
                    st_r.w_data, st_r.w_strb);
                ADDR_INFN_LO: st_nxt.infn_lo = wmerge(st_r.infn_lo,
                    st_r.w_data, st_r.w_strb);
                ADDR_INFN_HI: st_nxt.infn_hi = wmerge(st_r.infn_hi,
                    st_r.w_data, st_r.w_strb);
                ADDR_STATUS: clr_mask = wmerge(32'h0000_0000,
                    st_r.w_data, st_r.w_strb);
                default: clr_mask = 32'h0000_0000;
            endcase
        end
        if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // latched trips: write one to clear, a new event wins
        st_nxt.trips = (st_r.trips & ~clr_mask[ST_TRIP_POS +: 5]) |
                       trip_set;

        if (ar_take) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                ADDR_LEVELS: st_nxt.rdata = st_r.levels;
                ADDR_CTRL: st_nxt.rdata = st_r.ctrl;
                ADDR_RATED: st_nxt.rdata = st_r.rated;
                ADDR_INFN_LO: st_nxt.rdata = st_r.infn_lo;
                ADDR_INFN_HI: st_nxt.rdata = st_r.infn_hi;
                ADDR_STATUS: st_nxt.rdata = status;
                default: begin
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.rresp = RESP_SLVERR;
                end
            endcase
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= '0;
            st_r.levels <= LEVELS_RST;
            st_r.ctrl <= CTRL_RST;
            st_r.rated <= RATED_RST;
            st_r.infn_lo <= INFN_LO_RST;
            st_r.infn_hi <= INFN_HI_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = !st_r.aw_hold && !st_r.bvalid;
    assign s_axi_wready = !st_r.w_hold && !st_r.bvalid;
    assign s_axi_bvalid = st_r.bvalid;
    assign s_axi_bresp = st_r.bresp;
    assign s_axi_arready = !st_r.rvalid;
    assign s_axi_rvalid = st_r.rvalid;
    assign s_axi_rdata = st_r.rdata;
    assign s_axi_rresp = st_r.rresp;
    assign open_collector_output = st_r.oc;
    assign changeover_relay_output = st_r.relay;
    // [RL3] [RL12] [RL13] output shut off on any trip
    assign output_enable = ~|st_r.trips;
    assign fault = |st_r.trips;
    assign overload_warn_flag = st_r.warn;
    // [RL5] accel hold
    assign stall_hold_accel = st_r.stall[0];
    // [RL6] constant speed dip
    assign stall_force_decel = st_r.stall[1];
    // [RL7] decel hold
    assign stall_hold_decel = st_r.stall[2];
    // [RL10] stall indication
    assign stall_active = |st_r.stall;

endmodule

// ---- shared/mdp_pkg.sv ----
/*
 * constants, register map and state type of the protection monitor.
 * assumes a 25 MHz aclk and a 32-bit AXI4-Lite register port.
 */
package mdp_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_LEVELS = 8'h00;
    localparam logic [7:0] ADDR_CTRL = 8'h04;
    localparam logic [7:0] ADDR_RATED = 8'h08;
    localparam logic [7:0] ADDR_INFN_LO = 8'h0C;
    localparam logic [7:0] ADDR_INFN_HI = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    // warn 150 %, warn 10 s, trip 180 %, trip 60 s
    localparam logic [31:0] LEVELS_RST = 32'h3CB4_0A96;
    // stall select 0, trip enabled, phase loss off, stall 150 %,
    // open collector function 12, relay function 17
    localparam logic [31:0] CTRL_RST = 32'h110C_9608;
    localparam logic [31:0] RATED_RST = 32'h0064_0064;
    localparam logic [31:0] INFN_LO_RST = 32'h0000_0000;
    localparam logic [31:0] INFN_HI_RST = 32'h0706_0000;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int WARN_LVL_POS = 0;
    localparam int WARN_TIME_POS = 8;
    localparam int TRIP_LVL_POS = 16;
    localparam int TRIP_TIME_POS = 24;
    localparam int STALL_SEL_POS = 0;
    localparam int TRIP_EN_POS = 3;
    localparam int PLOSS_POS = 4;
    localparam int STALL_LVL_POS = 8;
    localparam int OC_FN_POS = 16;
    localparam int RELAY_FN_POS = 24;
    localparam int MOTOR_RATED_POS = 0;
    localparam int DRIVE_RATED_POS = 16;
    // status: 0 warn, 5:1 latched trips, 8:6 stall
    localparam int ST_WARN_POS = 0;
    localparam int ST_TRIP_POS = 1;
    localparam int ST_STALL_POS = 6;

    // ------------------------------------------------------------
    // function codes and timing
    // ------------------------------------------------------------
    localparam logic [4:0] FN_OVL_WARN = 5'h05;
    localparam logic [4:0] FN_DRV_OVL = 5'h06;
    localparam logic [4:0] FN_STALL = 5'h07;
    localparam logic [4:0] FN_RUN = 5'h0C;
    localparam logic [4:0] FN_FAULT = 5'h11;
    localparam logic [4:0] IN_EXT_NO = 5'h12;
    localparam logic [4:0] IN_EXT_NC = 5'h13;
    localparam logic [31:0] PCT_SCALE = 32'h0000_0064;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned TICK_S = 1;
    localparam int unsigned TICK_CYC = TICK_S * CLK_HZ;

    // trip index inside the trip vector
    localparam int TR_OVL = 0;
    localparam int TR_OUTPH = 1;
    localparam int TR_INPH = 2;
    localparam int TR_EXT = 3;
    localparam int TR_DRV = 4;

    typedef struct packed {
        logic [31:0] levels;
        logic [31:0] ctrl;
        logic [31:0] rated;
        logic [31:0] infn_lo;
        logic [31:0] infn_hi;
        logic [4:0] trips;
        logic warn;
        logic [2:0] stall;
        logic oc;
        logic relay;
        logic [24:0] presc;
        logic tick;
        logic [5:0] warn_cnt;
        logic [5:0] trip_cnt;
        logic aw_hold;
        logic [7:0] aw_addr;
        logic w_hold;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } mdp_state_t;

endpackage

// ---- dv/mdp_plant.sv ----
/* power stage and current sensor model.
   assumes bench-set demands; no current while disabled. */
`timescale 1ns/10ps
module mdp_plant (
    input logic aclk,
    input logic output_enable,
    input logic [15:0] motor_dem,
    input logic [15:0] drive_dem,
    output logic [15:0] motor_current,
    output logic [15:0] drive_current
);
    // ----
    // current collapses once the output is shut off
    // ----
    always_ff @(posedge aclk) begin
        motor_current <= output_enable ? motor_dem : 16'h0000;
        drive_current <= output_enable ? drive_dem : 16'h0000;
    end
endmodule

// ---- dv/mdp_monitor_asserts.sv ----
/* port assertions of the protection monitor.
   assumes it is bound onto mdp_monitor, one clock aclk. */
`timescale 1ns/10ps
module mdp_monitor_asserts (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_awready,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic s_axi_rvalid,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic ramp_accel,
    input logic ramp_const,
    input logic ramp_decel,
    input logic dc_link_high,
    input logic output_enable,
    input logic fault,
    input logic overload_warn_flag,
    input logic open_collector_output,
    input logic stall_hold_accel,
    input logic stall_force_decel,
    input logic stall_hold_decel,
    input logic stall_active
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ----
    // assertions
    // ----
    output_off_a: assert property (
        output_enable == !fault) else $error("oe on with fault");
    stall_or_a: assert property (
        stall_active == (stall_hold_accel | stall_force_decel |
        stall_hold_decel)) else $error("stall flag");
    accel_hold_a: assert property (
        stall_hold_accel |-> $past(ramp_accel)) else $error("accel hold");
    const_dec_a: assert property (
        stall_force_decel |-> $past(ramp_const)) else $error("forced decel");
    decel_hold_a: assert property (
        stall_hold_decel |-> $past(ramp_decel) && $past(dc_link_high))
        else $error("decel hold");
    trip_latch_a: assert property (
        $fell(fault) |-> $rose(s_axi_bvalid)) else $error("trip cleared");
    b_block_a: assert property (
        s_axi_bvalid |-> !s_axi_awready) else $error("aw taken during b");
    b_once_a: assert property (
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b twice");
    ar_gate_a: assert property (
        s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
    r_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no r");
    stall_c: cover property (stall_active);
    trip_c: cover property ($rose(fault));
    warn_c: cover property ($rose(overload_warn_flag));
    oc_c: cover property ($rose(open_collector_output));
endmodule

bind mdp_monitor mdp_monitor_asserts
    u_mdp_monitor_asserts (.aclk, .aresetn, .s_axi_awready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
    .s_axi_bready, .ramp_accel, .ramp_const, .ramp_decel, .dc_link_high,
    .output_enable, .fault, .overload_warn_flag, .open_collector_output,
    .stall_hold_accel, .stall_force_decel, .stall_hold_decel, .stall_active);

// ---- dv/tb_motor_drive_protection_monitor.sv ----
/* self-checking bench of the protection monitor.
   assumes mdp_plant as power stage, AXI4-Lite register access. */
`timescale 1ns/10ps
module tb_motor_drive_protection_monitor
    import mdp_pkg::*;
;
    localparam int unsigned TC = 10;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [15:0] motor_dem = 16'h0000, drive_dem = 16'h0000;
    logic [15:0] motor_current, drive_current;
    logic dc_link_high = 1'b0, ramp_accel = 1'b0, ramp_const = 1'b0;
    logic ramp_decel = 1'b0, run_active = 1'b0, cap_replace = 1'b0;
    logic [2:0] out_phase_lost = 3'h0, in_phase_lost = 3'h0, ph, e3;
    logic [7:0] multi_input = 8'h80;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, open_collector_output, changeover_relay_output;
    logic output_enable, fault, overload_warn_flag, stall_active;
    logic stall_hold_accel, stall_force_decel, stall_hold_decel;
    int fail_count = 0, n_tests = 0, ex, hi;

    always #20 aclk = ~aclk;

    mdp_monitor #(.TICK_CYCLES(TC)) u_mdp_monitor (.aclk, .aresetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .motor_current, .drive_current, .dc_link_high,
        .ramp_accel, .ramp_const, .ramp_decel, .run_active, .out_phase_lost,
        .in_phase_lost, .cap_replace, .multi_input, .open_collector_output,
        .changeover_relay_output, .output_enable, .fault, .overload_warn_flag,
        .stall_hold_accel, .stall_force_decel, .stall_hold_decel,
        .stall_active);
    mdp_plant u_mdp_plant (.aclk, .output_enable, .motor_dem, .drive_dem,
        .motor_current, .drive_current);

    // ----
    // tasks
    // ----
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task report_and_stop();
        $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task axi_rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d);
        chk(rs, RESP_OKAY);
    endtask
    task tick(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask
    task after(input logic e);
        tick(4);
        chk(fault, e);
        chk(changeover_relay_output, e);
    endtask
    task reclr();
        wr(ADDR_STATUS, 32'h0000_003E);
        tick(2);
        chk(fault, 1'b0);
    endtask
    function logic [31:0] mk_ctrl(input int ss, te, pl, oc, rl);
        return 32'(ss) | 32'(te) << TRIP_EN_POS | 32'(pl) << PLOSS_POS |
            32'h96 << STALL_LVL_POS | 32'(oc) << OC_FN_POS |
            32'(rl) << RELAY_FN_POS;
    endfunction

    // ----
    // main sequence
    // ----
    initial begin
        rd = $urandom(65);
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        axi_rd(ADDR_LEVELS);
        chk(rd, {8'h3C, 8'hB4, 8'h0A, 8'h96});
        axi_rd(ADDR_CTRL);
        chk(rd, {8'h11, 8'h0C, 8'h96, 8'h08});
        axi_rd(ADDR_INFN_HI);
        chk(rd, {8'h07, 8'h06, 16'h0000});
        axi_rd(8'h18);
        chk(rd, 32'h0000_0000);
        chk(rs, RESP_SLVERR);
        axi_wr(8'h18, 32'hFFFF_FFFF);
        chk(rs, RESP_SLVERR);
        @(posedge aclk);
        run_active <= 1'b1;
        tick(3);
        chk(open_collector_output, 1'b1);
        wr(ADDR_LEVELS, {8'h01, 8'h50, 8'h02, 8'h32});
        wr(ADDR_CTRL, mk_ctrl(0, 1, 0, 5, 5));
        motor_dem <= 16'h003C;
        tick(5);
        chk(overload_warn_flag, 1'b0);
        tick(19);
        chk({overload_warn_flag, open_collector_output}, 2'h3);
        chk(changeover_relay_output, 1'b1);
        @(posedge aclk);
        motor_dem <= 16'h0028;
        tick(4);
        chk({overload_warn_flag, open_collector_output}, 2'h0);
        wr(ADDR_CTRL, mk_ctrl(0, 0, 0, 12, 17));
        motor_dem <= 16'h005A;
        tick(30);
        chk(fault, 1'b0);
        wr(ADDR_CTRL, mk_ctrl(0, 1, 0, 12, 17));
        tick(TC + 5);
        chk({fault, output_enable}, 2'h2);
        axi_rd(ADDR_STATUS);
        chk(rd[ST_TRIP_POS + TR_OVL], 1'b1);
        motor_dem <= 16'h0000;
        reclr();
        for (int pl = 0; pl < 4; pl++) begin
            wr(ADDR_CTRL, mk_ctrl(0, 1, pl, 12, 17));
            for (int k = 0; k < 3; k++) begin
                ph = 3'h1 << ($urandom % 3);
                @(posedge aclk);
                out_phase_lost <= (k == 0) ? ph : 3'h0;
                in_phase_lost <= (k == 1) ? ph : 3'h0;
                cap_replace <= (k == 2);
                ex = (k == 0) ? pl % 2 : pl / 2;
                after(ex[0]);
                @(posedge aclk);
                out_phase_lost <= 3'h0;
                in_phase_lost <= 3'h0;
                cap_replace <= 1'b0;
                reclr();
            end
        end
        for (int i = 0; i < 4; i++) rd[8 * i +: 8] = 8'($urandom % 18);
        wr(ADDR_INFN_LO, rd);
        wr(ADDR_INFN_HI, 32'h1312_0000);
        multi_input <= 8'h8F;
        after(1'b0);
        for (int i = 0; i < 2; i++) begin
            @(posedge aclk);
            multi_input <= i ? 8'h00 : 8'hC0;
            after(1'b1);
            @(posedge aclk);
            multi_input <= 8'h80;
            reclr();
        end
        wr(ADDR_CTRL, mk_ctrl(0, 1, 0, 6, 17));
        drive_dem <= 16'h0064;
        after(1'b0);
        drive_dem <= 16'h0065;
        after(1'b1);
        chk(open_collector_output, 1'b1);
        drive_dem <= 16'h0000;
        reclr();
        for (int ss = 0; ss < 8; ss++) begin
            wr(ADDR_CTRL, mk_ctrl(ss, 0, 0, 7, 17));
            for (int p = 0; p < 3; p++) begin
                hi = $urandom % 4;
                @(posedge aclk);
                motor_dem <= hi[0] ? 16'h0097 : 16'h0096;
                dc_link_high <= hi[1];
                {ramp_decel, ramp_const, ramp_accel} <= 3'h1 << p;
                e3 = {p == 2 && ss[2] && hi[1], p == 1 && ss[1] && hi[0],
                    p == 0 && ss[0] && hi[0]};
                tick(4);
                chk({stall_active, stall_hold_decel, stall_force_decel,
                    stall_hold_accel}, {|e3, e3});
                chk(open_collector_output, |e3);
            end
        end
        report_and_stop();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        fail_count++;
        report_and_stop();
    end
endmodule
